// ===== hw/spi_eeprom_write_protect_status.sv
// Write latch, status register and write protection of a serial EEPROM slave.
//
// Function
// - No array or status write cycle starts unless the write latch is set.
// - Latch clears at power-up, clear-latch command, and end of status or array write.
// - Status read is accepted at any time, also during a write cycle.
// - Status byte repeats on the output while chip select stays low.
// - Status: arm bit 7, zero bits 6-4, protect bits 3-2, latch 1, busy 0.
// - Busy flag is 1 during an internal write, 0 otherwise, never written.
// - Latch flag mirrors the latch; latch commands ignore status protection.
// - Protect bits change only by status write and are kept nonvolatile.
// - Protect codes guard none, 1800h-1FFFh, 1000h-1FFFh, or all addresses.
// - Hardware protection is on only with protect pin low and arm bit set.
// - Hardware protection refuses only status writes; all else proceeds.
// - A write cycle already started ignores a later protect pin fall.
// - Arm bit is nonvolatile; when clear the protect pin is ignored.
// - Protection matrix of latch, arm bit, pin over blocks and status.
// - Chip select rise after a valid status write starts a write cycle.
// - Array requests during a write cycle are refused; programming continues.
// - Power-up in standby, latch clear, output off; select needs a fall.
// - Chip select rise enters standby after any running write cycle ends.
// - Serial output is high impedance while deselected.
// - Input sampled on rising serial clock, output changed after falling edge.
// - Set-latch opcode 06h, clear-latch 04h, most significant bit first.
// - Busy holds from chip select rise until the write ends, at most 5 ms.
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_write_protect_status #(
    parameter int unsigned WRITE_CYCLES = eeprom_prot_pkg::WRITE_CYC
) (
    // System clock domain
    input  wire logic                       sys_clk,
    input  wire logic                       rstn,
    input  wire logic                       ce,
    // Serial link pins
    input  wire logic                       sck,
    input  wire logic                       cs_n,
    input  wire logic                       si,
    output logic                            so_out,
    output logic                            so_en_n,
    input  wire logic                       wp_n,
    // Nonvolatile store of the protection bits
    input  wire eeprom_prot_pkg::nv_bits_t  nv_in,
    output eeprom_prot_pkg::nv_bits_t       nv_out,
    output logic                            nv_commit,
    // Array write requests from the neighbouring write sequencer
    input  wire eeprom_prot_pkg::arr_req_t  arr_req,
    output logic                            arr_grant,
    output logic                            arr_refused,
    // Observed state
    output eeprom_prot_pkg::status_t        status
);

    // The write timer is 18 bits wide, so longer cycles cannot be counted.
    if (WRITE_CYCLES < 1 || WRITE_CYCLES > 262143) begin : g_bad_cycles
        $error("WRITE_CYCLES out of range");
    end

    // ---------------- Link domain: serial clock, rising edge ----------------

    // Set while deselected; the first rising edge of a frame restarts the counts.
    logic       first_r;
    logic [7:0] shift_r, shift_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [1:0] bytes_r, bytes_nxt;
    logic [7:0] op_r, op_nxt;
    logic [7:0] data_r, data_nxt;
    logic       tog_r, tog_nxt;
    logic [7:0] st_s1_r, st_s2_r;

    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    always_comb begin
        logic [2:0] b;
        logic [1:0] n;
        b         = first_r ? 3'h0 : bit_r;
        n         = first_r ? 2'h0 : bytes_r;
        shift_nxt = {shift_r[6:0], si};
        bit_nxt   = b + 3'h1;
        bytes_nxt = n;
        op_nxt    = op_r;
        data_nxt  = data_r;
        tog_nxt   = first_r ? ~tog_r : tog_r;
        if (b == 3'h7) begin
            // Saturation at three bytes makes every longer frame invalid.
            if (n != 2'h3) begin
                bytes_nxt = n + 2'h1;
            end
            if (n == 2'h0) begin
                op_nxt = shift_nxt;
            end
            if (n == 2'h1) begin
                data_nxt = shift_nxt;
            end
        end
    end

    // The frame fields stay still after chip select rises, until the next
    // frame's first clock, so the system domain may read them at frame end.
    always_ff @(posedge sck or negedge rstn) begin
        if (!rstn) begin
            shift_r <= 8'h00;
            bit_r   <= 3'h0;
            bytes_r <= 2'h0;
            op_r    <= 8'h00;
            data_r  <= 8'h00;
            tog_r   <= 1'b0;
            st_s1_r <= 8'h00;
            st_s2_r <= 8'h00;
        end else begin
            shift_r <= shift_nxt;
            bit_r   <= bit_nxt;
            bytes_r <= bytes_nxt;
            op_r    <= op_nxt;
            data_r  <= data_nxt;
            tog_r   <= tog_nxt;
            st_s1_r <= status;
            st_s2_r <= st_s1_r;
        end
    end

    // ---------------- Link domain: serial clock, falling edge ---------------

    logic so_r, so_nxt;
    logic rd_r, rd_nxt;

    always_comb begin
        rd_nxt = (bytes_r != 2'h0) && (op_r == eeprom_prot_pkg::OP_STAT_READ);
        so_nxt = st_s2_r[~bit_r];
    end

    // Chip select high clears the driver at once, not at a clock edge.
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            rd_r <= 1'b0;
            so_r <= 1'b1;
        end else begin
            rd_r <= rd_nxt;
            so_r <= so_nxt;
        end
    end

    assign so_out  = so_r;
    assign so_en_n = ~rd_r;

    // ---------------- System domain -----------------------------------------

    function automatic logic blk_protected(input logic [1:0] bp,
                                           input logic [eeprom_prot_pkg::ADDR_W-1:0] a);
        case (bp)
            eeprom_prot_pkg::BP_NONE:    blk_protected = 1'b0;
            eeprom_prot_pkg::BP_QUARTER: blk_protected = a >= eeprom_prot_pkg::QUARTER_LO;
            eeprom_prot_pkg::BP_HALF:    blk_protected = a >= eeprom_prot_pkg::HALF_LO;
            default:                     blk_protected = 1'b1;
        endcase
    endfunction

    typedef enum logic [1:0] {S_LOAD, S_IDLE, S_WRITE} state_t;

    logic       cs_s1_r, cs_s2_r, cs_d_r;
    logic       wp_s1_r, wp_s2_r;
    logic       tg_s1_r, tg_s2_r, seen_r;
    state_t     state_r, state_nxt;
    logic       latch_r, latch_nxt;
    logic [17:0] tmr_r, tmr_nxt;
    logic       swr_r, swr_nxt;
    eeprom_prot_pkg::nv_bits_t nv_r, nv_nxt, pend_r, pend_nxt;
    logic       commit_r, commit_nxt;
    logic       grant_r, grant_nxt;
    logic       refuse_r, refuse_nxt;
    logic       seen_nxt;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r  <= 1'b1;
            wp_s1_r <= 1'b1;
            wp_s2_r <= 1'b1;
            tg_s1_r <= 1'b0;
            tg_s2_r <= 1'b0;
        end else if (ce) begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_d_r  <= cs_s2_r;
            wp_s1_r <= wp_n;
            wp_s2_r <= wp_s1_r;
            tg_s1_r <= tog_r;
            tg_s2_r <= tg_s1_r;
        end
    end

    logic frame_end;
    logic hw_prot;
    logic busy;
    assign frame_end = cs_s2_r & ~cs_d_r & (tg_s2_r != seen_r);
    assign hw_prot   = nv_r.arm & ~wp_s2_r;
    assign busy      = (state_r == S_WRITE);

    always_comb begin
        state_nxt  = state_r;
        latch_nxt  = latch_r;
        tmr_nxt    = tmr_r;
        swr_nxt    = swr_r;
        nv_nxt     = nv_r;
        pend_nxt   = pend_r;
        commit_nxt = 1'b0;
        grant_nxt  = 1'b0;
        refuse_nxt = 1'b0;
        seen_nxt   = frame_end ? tg_s2_r : seen_r;
        case (state_r)
            S_LOAD: begin
                nv_nxt    = nv_in;
                state_nxt = S_IDLE;
            end
            S_IDLE: begin
                if (frame_end && bit_r == 3'h0) begin
                    if (bytes_r == eeprom_prot_pkg::CMD_BYTES) begin
                        if (op_r == eeprom_prot_pkg::OP_SET_LATCH) begin
                            latch_nxt = 1'b1;
                        end
                        if (op_r == eeprom_prot_pkg::OP_CLEAR_LATCH) begin
                            latch_nxt = 1'b0;
                        end
                    end
                    if (bytes_r == eeprom_prot_pkg::SWR_BYTES &&
                        op_r == eeprom_prot_pkg::OP_STAT_WRITE &&
                        latch_r && !hw_prot) begin
                        pend_nxt.arm = data_r[eeprom_prot_pkg::ST_ARM_BIT];
                        pend_nxt.bp  = data_r[eeprom_prot_pkg::ST_BP_HI_BIT:eeprom_prot_pkg::ST_BP_LO_BIT];
                        swr_nxt      = 1'b1;
                        tmr_nxt      = 18'(WRITE_CYCLES - 1);
                        state_nxt    = S_WRITE;
                    end
                end else if (arr_req.req) begin
                    if (latch_r && !blk_protected(nv_r.bp, arr_req.addr)) begin
                        grant_nxt = 1'b1;
                        swr_nxt   = 1'b0;
                        tmr_nxt   = 18'(WRITE_CYCLES - 1);
                        state_nxt = S_WRITE;
                    end else begin
                        refuse_nxt = 1'b1;
                    end
                end
            end
            S_WRITE: begin
                // Protection was judged at the start; the pin no longer matters.
                refuse_nxt = arr_req.req;
                if (tmr_r == 18'h00000) begin
                    latch_nxt = 1'b0;
                    if (swr_r) begin
                        nv_nxt     = pend_r;
                        commit_nxt = 1'b1;
                    end
                    state_nxt = S_IDLE;
                end else begin
                    tmr_nxt = tmr_r - 18'h00001;
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r  <= S_LOAD;
            latch_r  <= eeprom_prot_pkg::LATCH_RST;
            tmr_r    <= 18'h00000;
            swr_r    <= 1'b0;
            nv_r     <= '0;
            pend_r   <= '0;
            commit_r <= 1'b0;
            grant_r  <= 1'b0;
            refuse_r <= 1'b0;
            seen_r   <= 1'b0;
        end else if (ce) begin
            state_r  <= state_nxt;
            latch_r  <= latch_nxt;
            tmr_r    <= tmr_nxt;
            swr_r    <= swr_nxt;
            nv_r     <= nv_nxt;
            pend_r   <= pend_nxt;
            commit_r <= commit_nxt;
            grant_r  <= grant_nxt;
            refuse_r <= refuse_nxt;
            seen_r   <= seen_nxt;
        end
    end

    always_comb begin
        status       = '0;
        status.arm   = nv_r.arm;
        status.bp    = nv_r.bp;
        status.latch = latch_r;
        status.busy  = busy;
    end

    assign nv_out      = nv_r;
    assign nv_commit   = commit_r;
    assign arr_grant   = grant_r;
    assign arr_refused = refuse_r;

endmodule
`default_nettype wire

// ===== pkg/eeprom_prot_pkg.sv
// Constants and types shared by the serial EEPROM protection and status logic.
`default_nettype none
package eeprom_prot_pkg;
    // Command opcodes, sent most significant bit first.
    localparam logic [7:0] OP_SET_LATCH   = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_STAT_READ   = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE  = 8'h01;

    // Status byte field positions.
    localparam int unsigned ST_ARM_BIT   = 7;
    localparam int unsigned ST_BP_HI_BIT = 3;
    localparam int unsigned ST_BP_LO_BIT = 2;
    localparam int unsigned ST_LATCH_BIT = 1;
    localparam int unsigned ST_BUSY_BIT  = 0;

    // Block protect codes and the lower bound of each protected range.
    localparam logic [1:0]  BP_NONE    = 2'h0;
    localparam logic [1:0]  BP_QUARTER = 2'h1;
    localparam logic [1:0]  BP_HALF    = 2'h2;
    localparam logic [1:0]  BP_ALL     = 2'h3;
    localparam logic [12:0] QUARTER_LO = 13'h1800;
    localparam logic [12:0] HALF_LO    = 13'h1000;
    localparam int unsigned ADDR_W     = 13;

    // Frame lengths, in whole bytes, of the commands that act at frame end.
    localparam logic [1:0] CMD_BYTES   = 2'h1;
    localparam logic [1:0] SWR_BYTES   = 2'h2;

    // Reset values of volatile state.
    localparam logic       LATCH_RST   = 1'b0;
    localparam logic       BUSY_RST    = 1'b0;

    // Internal write cycle: longest time in ms and the system clock rate.
    localparam int unsigned WRITE_MS   = 5;
    localparam int unsigned SYS_HZ     = 40000000;
    localparam int unsigned WRITE_CYC  = WRITE_MS * (SYS_HZ / 1000);

    typedef struct packed {
        logic       arm;
        logic [1:0] bp;
    } nv_bits_t;

    typedef struct packed {
        logic       arm;
        logic [2:0] spare;
        logic [1:0] bp;
        logic       latch;
        logic       busy;
    } status_t;

    typedef struct packed {
        logic              req;
        logic [ADDR_W-1:0] addr;
    } arr_req_t;
endpackage
`default_nettype wire

// ===== sim/spi_eeprom_write_protect_status_assertions.sv
// Port checks for the EEPROM protection and status block.
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_write_protect_status_assertions #(
    parameter int unsigned WRITE_CYCLES = 20
) (
    // Clock and reset
    input wire logic                      sys_clk,
    input wire logic                      rstn,
    input wire logic                      ce,
    // Link and array side
    input wire logic                      cs_n,
    input wire logic                      so_en_n,
    input wire eeprom_prot_pkg::arr_req_t arr_req,
    input wire logic                      arr_grant,
    input wire logic                      arr_refused,
    // State
    input wire eeprom_prot_pkg::nv_bits_t nv_out,
    input wire logic                      nv_commit,
    input wire eeprom_prot_pkg::status_t  status
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    int unsigned busy_cnt_r;
    int unsigned busy_cnt_nxt;
    logic [1:0]  up_r;
    logic [1:0]  up_nxt;

    // The stored bits load on the first edges after reset, so changes then are not commits.
    always_comb begin
        busy_cnt_nxt = status.busy ? busy_cnt_r + {31'h0, ce} : 32'h0;
        up_nxt       = (ce && up_r != 2'h3) ? up_r + 2'h1 : up_r;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_r <= 32'h0;
            up_r       <= 2'h0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
            up_r       <= up_nxt;
        end
    end

    sequence s_req_busy;
        arr_req.req && ce && status.busy;
    endsequence
    sequence s_write_end;
        !status.busy && $past(status.busy);
    endsequence

    a_grant_cause: assert property (arr_grant |-> $past(arr_req.req) && $past(status.latch) && status.busy)
        else $error("grant without request or latch");
    a_busy_refuse: assert property (s_req_busy |=> arr_refused && !arr_grant)
        else $error("request during write not refused");
    a_latch_end: assert property (s_write_end |-> !status.latch)
        else $error("latch still set after write");
    a_commit_end: assert property (nv_commit |-> s_write_end)
        else $error("commit outside write end");
    a_nv_only_commit: assert property (up_r == 2'h3 && $changed(nv_out) |-> nv_commit)
        else $error("protect bits changed without commit");
    a_status_fields: assert property (status.arm == nv_out.arm && status.bp == nv_out.bp && status.spare == 3'h0)
        else $error("status fields wrong");
    a_so_off: assert property (cs_n |-> so_en_n)
        else $error("output driven while deselected");
    a_busy_span: assert property ($fell(status.busy) |-> busy_cnt_r == WRITE_CYCLES)
        else $error("write cycle length wrong");
endmodule

bind spi_eeprom_write_protect_status spi_eeprom_write_protect_status_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .cs_n(cs_n), .so_en_n(so_en_n), .arr_req(arr_req),
    .arr_grant(arr_grant), .arr_refused(arr_refused), .nv_out(nv_out), .nv_commit(nv_commit), .status(status));
`default_nettype wire

// ===== sim/spi_eeprom_write_protect_status_tb.sv
// Self-checking bench for the EEPROM protection and status block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module spi_eeprom_write_protect_status_tb;
    localparam int unsigned WC = 200;
    logic                      sys_clk = 1'b0;
    logic                      rstn    = 1'b0;
    logic                      ce      = 1'b1;
    logic                      wp_n    = 1'b1;
    logic                      cs_n, sck, si, so_out, so_en_n, arr_grant, arr_refused, nv_commit, exp_g, g;
    eeprom_prot_pkg::nv_bits_t nv_in   = 3'h2;
    eeprom_prot_pkg::nv_bits_t nv_out;
    eeprom_prot_pkg::arr_req_t arr_req = '0;
    eeprom_prot_pkg::status_t  status;
    logic                      exp_q[$];
    logic [23:0]               rx;
    logic [7:0]                lfsr    = 8'h38;
    logic                      arm     = 1'b0;
    logic                      latch   = 1'b0;
    logic [1:0]                bp      = 2'h2;
    logic [12:0]               addrs[6] = '{13'h0000, 13'h0fff, 13'h1000, 13'h17ff, 13'h1800, 13'h1fff};
    int                        fails   = 0;
    int                        n_tests = 0;

    always #12.5 sys_clk = ~sys_clk;

    spi_eeprom_write_protect_status #(.WRITE_CYCLES(WC)) dut (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
        .so_en_n(so_en_n), .wp_n(wp_n), .nv_in(nv_in), .nv_out(nv_out), .nv_commit(nv_commit),
        .arr_req(arr_req), .arr_grant(arr_grant), .arr_refused(arr_refused), .status(status));
    spi_master_model m (.cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out), .so_en_n(so_en_n));

    // Stands in for the nonvolatile cells, so bits survive a reset.
    always @(posedge sys_clk) if (nv_commit) nv_in <= nv_out;

    always @(posedge sys_clk) begin
        if (arr_grant || arr_refused) begin
            exp_g = exp_q.pop_front();
            `CHK("grant", exp_g, arr_grant)
        end
    end

    function automatic logic [7:0] next_lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    function automatic logic prot(input logic [1:0] b, input logic [12:0] a);
        return b == 2'h3 || (b == 2'h2 && a >= 13'h1000) || (b == 2'h1 && a >= 13'h1800);
    endfunction

    task automatic test_done();
        $display("tests %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic status_read_cmd(input logic busy);
        logic [7:0] e;
        e = {arm, 3'h0, bp, latch, busy};
        m.xfer({eeprom_prot_pkg::OP_STAT_READ, 16'h0}, 24, rx);
        `CHK("status", e, rx[15:8])
        `CHK("repeat", e, rx[7:0])
    endtask

    task automatic setl(input logic [7:0] op, input int n);
        m.xfer({op, 16'h0}, n, rx);
    endtask

    task automatic status_write_cmd(input logic [7:0] d, input int n);
        m.xfer({eeprom_prot_pkg::OP_STAT_WRITE, d, 8'h0}, n, rx);
    endtask

    task automatic wait_idle();
        repeat (WC + 20) if (status.busy === 1'b1) @(negedge sys_clk);
    endtask

    task automatic arr(input logic [12:0] a, input logic bsy, output logic ok);
        ok = latch && !bsy && !prot(bp, a);
        exp_q.push_back(ok);
        @(posedge sys_clk) arr_req <= {1'b1, a};
        @(posedge sys_clk) arr_req <= '0;
        repeat (2) @(posedge sys_clk);
    endtask

    // One status write with the latch set; the fields take the new values when the write ends.
    task automatic swr(input logic [7:0] d, input logic takes);
        setl(eeprom_prot_pkg::OP_SET_LATCH, 8);
        latch = 1'b1;
        status_write_cmd(d, 16);
        if (takes) begin
            status_read_cmd(1'b1);
            wait_idle();
            {arm, bp, latch} = {d[7], d[3:2], 1'b0};
        end
        status_read_cmd(1'b0);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        status_read_cmd(1'b0);
        arr(13'h0000, 1'b0, g);
        setl(eeprom_prot_pkg::OP_SET_LATCH, 8);
        latch = 1'b1;
        setl(eeprom_prot_pkg::OP_CLEAR_LATCH, 9);
        status_read_cmd(1'b0);
        setl(eeprom_prot_pkg::OP_CLEAR_LATCH, 8);
        latch = 1'b0;
        status_write_cmd(8'h8c, 16);
        status_read_cmd(1'b0);
        for (int b = 0; b < 4; b++) begin
            swr({6'h0, b[1:0]} << 2 | 8'h03, 1'b1);
            for (int k = 0; k < 7; k++) begin
                lfsr = next_lfsr(lfsr);
                setl(eeprom_prot_pkg::OP_SET_LATCH, 8);
                latch = 1'b1;
                arr(k < 6 ? addrs[k] : {lfsr[4:0], lfsr}, 1'b0, g);
                if (g) begin
                    status_read_cmd(1'b1);
                    arr(13'h0000, 1'b1, g);
                    wait_idle();
                    latch = 1'b0;
                end
            end
        end
        swr(8'h80, 1'b1);
        @(posedge sys_clk) wp_n <= 1'b0;
        swr(8'h8c, 1'b0);
        arr(13'h0000, 1'b0, g);
        wait_idle();
        latch = 1'b0;
        @(posedge sys_clk) wp_n <= 1'b1;
        setl(eeprom_prot_pkg::OP_SET_LATCH, 8);
        status_write_cmd(8'h0c, 16);
        @(posedge sys_clk) wp_n <= 1'b0;
        wait_idle();
        {arm, bp, latch} = 4'h6;
        status_read_cmd(1'b0);
        swr(8'h04, 1'b1);
        setl(eeprom_prot_pkg::OP_SET_LATCH, 8);
        latch = 1'b1;
        status_write_cmd(8'h00, 15);
        status_read_cmd(1'b0);
        @(posedge sys_clk) rstn <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        latch = 1'b0;
        repeat (4) @(posedge sys_clk);
        status_read_cmd(1'b0);
        `CHK("pending", 0, exp_q.size())
        test_done();
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        fails++;
        test_done();
    end
endmodule
`default_nettype wire

// ===== sim/spi_master_model.sv
// Serial bus master that frames commands toward the EEPROM slave.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    // Serial pins
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so_out,
    input  wire logic so_en_n
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b1;
    end

    // The clock stands still between frames; the odd offset keeps it off the system clock phase.
    task automatic xfer(input logic [23:0] d, input int n, output logic [23:0] r);
        r = 24'h0;
        #1.3 cs_n = 1'b0;
        // Frames are left aligned in d, so a short frame sends the opcode first.
        for (int i = 23; i > 23 - n; i--) begin
            si = d[i];
            #3 sck = 1'b1;
            r = {r[22:0], so_en_n ? 1'bz : so_out};
            #3 sck = 1'b0;
        end
        #3 cs_n = 1'b1;
        si = ~si;
        #150;
    endtask
endmodule
`default_nettype wire
